// ===== verilog/phzds_pkg.sv
// package: register map, field positions and reset values of the pll holdover/zero-delay bank
package phzds_pkg;

  // ******************************************************************
  // register offsets on the serial control port
  // ******************************************************************
  localparam logic [9:0] ADDR_HOLDOVER_CTRL = 10'h01d;
  localparam logic [9:0] ADDR_ZERO_DELAY    = 10'h01e;
  localparam logic [9:0] ADDR_STATUS        = 10'h01f;

  // ******************************************************************
  // holdover_and_status_control fields
  // ******************************************************************
  localparam int HSC_STATUS_DIS_BIT = 4;
  localparam int HSC_LD_CMP_EN_BIT  = 3;
  localparam int HSC_EXT_HOLD_BIT   = 1;
  localparam int HSC_HOLD_EN_BIT    = 0;
  localparam logic [7:0] HSC_WRITE_MASK = 8'h1b;
  localparam logic [7:0] HSC_RESET      = 8'h00;

  // ******************************************************************
  // zero_delay_control fields
  // ******************************************************************
  localparam int ZDC_DIV_LSB     = 3;
  localparam int ZDC_DIV_MSB     = 4;
  localparam int ZDC_EXT_MODE_BIT = 2;
  localparam int ZDC_ENABLE_BIT  = 1;
  localparam logic [7:0] ZDC_WRITE_MASK = 8'h1e;
  localparam logic [7:0] ZDC_RESET      = 8'h00;

  // ******************************************************************
  // pll_readback_status fields
  // ******************************************************************
  localparam int STS_VCO_CAL_BIT   = 6;
  localparam int STS_HOLD_ACT_BIT  = 5;
  localparam int STS_SECOND_REFERENCE_INPUT_SEL_BIT  = 4;
  localparam int STS_VCO_FREQ_BIT  = 3;
  localparam int STS_SECOND_REFERENCE_INPUT_FREQ_BIT = 2;
  localparam int STS_FIRST_REFERENCE_INPUT_FREQ_BIT = 1;
  localparam int STS_LOCK_BIT      = 0;
  localparam int STS_WIDTH         = 7;
  localparam logic [6:0] STS_RESET = 7'h00;

  // ******************************************************************
  // misc values
  // ******************************************************************
  localparam logic [7:0] READ_UNMAPPED = 8'h00;
  localparam logic [7:0] RDATA_RESET   = 8'h00;
  localparam logic [3:0] HCTL_RESET    = 4'h8;
  localparam logic [2:0] ZCTL_RESET    = 3'h0;
  localparam logic [1:0] DIV_RESET     = 2'h0;

  typedef enum logic [1:0] {
    PHZDS_ZD_OFF,
    PHZDS_ZD_INTERNAL,
    PHZDS_ZD_EXTERNAL
  } phzds_zd_mode_t;

endpackage

// ===== verilog/phzds_sample_reg.sv
// module: capture register that follows its source only while refresh is on
`timescale 1ns/1ns
`default_nettype none

module phzds_sample_reg #(
  parameter int              WIDTH = 7,
  parameter logic [WIDTH-1:0] INIT = '0
) (
  input  wire logic             clk,
  input  wire logic             resetn,
  input  wire logic             refresh,
  input  wire logic [WIDTH-1:0] src,
  output logic      [WIDTH-1:0] q
);

  logic [WIDTH-1:0] q_r;
  logic [WIDTH-1:0] q_nxt;

  // holding the last value lets software read a frozen snapshot
  always_comb
  begin
    q_nxt = q_r;
    if (refresh)
    begin
      q_nxt = src;
    end
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      q_r <= INIT;
    end
    else
    begin
      q_r <= q_nxt;
    end
  end

  assign q = q_r;

endmodule

`default_nettype wire

// ===== verilog/phzds_top.sv
// module: pll holdover, zero-delay and readback status register bank
`timescale 1ns/1ns
`default_nettype none

module phzds_top (
  input  wire logic       clk,
  input  wire logic       resetn,
  // register port from the serial control port engine
  input  wire logic [9:0] reg_addr,
  input  wire logic       reg_wr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata,
  output logic            reg_rvalid,
  // status sources from the pll and monitor circuits
  input  wire logic       vco_cal_done,
  input  wire logic       holdover_active,
  input  wire logic       second_reference_selected,
  input  wire logic       vco_freq_above,
  input  wire logic       second_reference_input_freq_above,
  input  wire logic       first_reference_input_freq_above,
  input  wire logic       digital_lock,
  // lock_detect_pin level as seen by the comparator
  input  wire logic       lock_detect_pin,
  // controls to the holdover controller
  output logic            holdover_enable,
  output logic            internal_holdover_en,
  output logic            external_holdover_sel,
  output logic            holdover_lock_detect,
  // controls to the zero-delay logic
  output logic            zero_delay_en,
  output logic            zero_delay_internal,
  output logic            zero_delay_external,
  output logic      [1:0] zero_delay_fb_div
);

  // ******************************************************************
  // register write side
  // ******************************************************************
  logic [7:0] hsc_r;
  logic [7:0] hsc_nxt;
  logic [7:0] zdc_r;
  logic [7:0] zdc_nxt;

  always_comb
  begin
    hsc_nxt = hsc_r;
    zdc_nxt = zdc_r;
    if (reg_wr)
    begin
      case (reg_addr)
        phzds_pkg::ADDR_HOLDOVER_CTRL:
        begin
          hsc_nxt = reg_wdata & phzds_pkg::HSC_WRITE_MASK;
        end
        phzds_pkg::ADDR_ZERO_DELAY:
        begin
          zdc_nxt = reg_wdata & phzds_pkg::ZDC_WRITE_MASK;
        end
        phzds_pkg::ADDR_STATUS:
        begin
          // the snapshot is read only; a write must not disturb it
          hsc_nxt = hsc_r;
          zdc_nxt = zdc_r;
        end
        default:
        begin
          // unmapped writes change nothing
          hsc_nxt = hsc_r;
          zdc_nxt = zdc_r;
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      hsc_r <= phzds_pkg::HSC_RESET;
      zdc_r <= phzds_pkg::ZDC_RESET;
    end
    else
    begin
      hsc_r <= hsc_nxt;
      zdc_r <= zdc_nxt;
    end
  end

  // ******************************************************************
  // readback status capture
  // ******************************************************************
  logic       refresh_on;
  logic [6:0] sts_src;
  logic [6:0] sts_q;

  assign refresh_on = ~hsc_r[phzds_pkg::HSC_STATUS_DIS_BIT];

  always_comb
  begin
    sts_src = '0;
    sts_src[phzds_pkg::STS_VCO_CAL_BIT]   = vco_cal_done;
    sts_src[phzds_pkg::STS_HOLD_ACT_BIT]  = holdover_active;
    sts_src[phzds_pkg::STS_SECOND_REFERENCE_INPUT_SEL_BIT]  =
      second_reference_selected;
    sts_src[phzds_pkg::STS_VCO_FREQ_BIT]  = vco_freq_above;
    sts_src[phzds_pkg::STS_SECOND_REFERENCE_INPUT_FREQ_BIT] =
      second_reference_input_freq_above;
    sts_src[phzds_pkg::STS_FIRST_REFERENCE_INPUT_FREQ_BIT] =
      first_reference_input_freq_above;
    sts_src[phzds_pkg::STS_LOCK_BIT]      = digital_lock;
  end

  // one cycle of capture latency; a frozen snapshot stays readable
  phzds_sample_reg #(
    .WIDTH (phzds_pkg::STS_WIDTH),
    .INIT  (phzds_pkg::STS_RESET)
  ) u_status (
    .clk     (clk),
    .resetn  (resetn),
    .refresh (refresh_on),
    .src     (sts_src),
    .q       (sts_q)
  );

  // ******************************************************************
  // register read side
  // ******************************************************************
  logic [7:0] rdata_r;
  logic [7:0] rdata_nxt;
  logic       rvalid_r;
  logic       rvalid_nxt;

  always_comb
  begin
    rdata_nxt  = rdata_r;
    rvalid_nxt = reg_rd;
    if (reg_rd)
    begin
      case (reg_addr)
        phzds_pkg::ADDR_HOLDOVER_CTRL:
        begin
          rdata_nxt = hsc_r;
        end
        phzds_pkg::ADDR_ZERO_DELAY:
        begin
          rdata_nxt = zdc_r;
        end
        phzds_pkg::ADDR_STATUS:
        begin
          rdata_nxt = {1'b0, sts_q};
        end
        default:
        begin
          rdata_nxt = phzds_pkg::READ_UNMAPPED;
        end
      endcase
    end
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      rdata_r  <= phzds_pkg::RDATA_RESET;
      rvalid_r <= 1'b0;
    end
    else
    begin
      rdata_r  <= rdata_nxt;
      rvalid_r <= rvalid_nxt;
    end
  end

  assign reg_rdata  = rdata_r;
  assign reg_rvalid = rvalid_r;

  // ******************************************************************
  // holdover controls
  // ******************************************************************
  // outputs are registered, so holdover_lock_detect follows a pin change by one clock
  // and each output follows a write by two; the analog side cares about levels, not edges
  logic [3:0] hctl_nxt;
  logic [3:0] hctl_r;

  always_comb
  begin
    hctl_nxt    = '0;
    hctl_nxt[0] = hsc_r[phzds_pkg::HSC_HOLD_EN_BIT];
    hctl_nxt[1] = hsc_r[phzds_pkg::HSC_HOLD_EN_BIT] &
                  ~hsc_r[phzds_pkg::HSC_EXT_HOLD_BIT];
    hctl_nxt[2] = hsc_r[phzds_pkg::HSC_EXT_HOLD_BIT];
    // comparator off: controller must see a locked (high) pin
    if (hsc_r[phzds_pkg::HSC_LD_CMP_EN_BIT])
    begin
      hctl_nxt[3] = lock_detect_pin;
    end
    else
    begin
      hctl_nxt[3] = 1'b1;
    end
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      hctl_r <= phzds_pkg::HCTL_RESET;
    end
    else
    begin
      hctl_r <= hctl_nxt;
    end
  end

  assign holdover_enable       = hctl_r[0];
  assign internal_holdover_en  = hctl_r[1];
  assign external_holdover_sel = hctl_r[2];
  assign holdover_lock_detect  = hctl_r[3];

  // ******************************************************************
  // zero-delay controls
  // ******************************************************************
  phzds_pkg::phzds_zd_mode_t zd_mode;
  logic [2:0]                zctl_nxt;
  logic [2:0]                zctl_r;
  logic [1:0]                div_nxt;
  logic [1:0]                div_r;

  always_comb
  begin
    zd_mode = phzds_pkg::PHZDS_ZD_OFF;
    if (zdc_r[phzds_pkg::ZDC_ENABLE_BIT])
    begin
      if (zdc_r[phzds_pkg::ZDC_EXT_MODE_BIT])
      begin
        zd_mode = phzds_pkg::PHZDS_ZD_EXTERNAL;
      end
      else
      begin
        zd_mode = phzds_pkg::PHZDS_ZD_INTERNAL;
      end
    end
    zctl_nxt    = '0;
    zctl_nxt[0] = zdc_r[phzds_pkg::ZDC_ENABLE_BIT];
    case (zd_mode)
      phzds_pkg::PHZDS_ZD_INTERNAL:
      begin
        zctl_nxt[1] = 1'b1;
      end
      phzds_pkg::PHZDS_ZD_EXTERNAL:
      begin
        zctl_nxt[2] = 1'b1;
      end
      default:
      begin
        zctl_nxt[2:1] = 2'h0;
      end
    endcase
    // the divider choice passes even while zero delay is off, so it is
    // already in place when the function gets enabled
    div_nxt = zdc_r[phzds_pkg::ZDC_DIV_MSB:
                    phzds_pkg::ZDC_DIV_LSB];
  end

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      zctl_r <= phzds_pkg::ZCTL_RESET;
      div_r  <= phzds_pkg::DIV_RESET;
    end
    else
    begin
      zctl_r <= zctl_nxt;
      div_r  <= div_nxt;
    end
  end

  assign zero_delay_en         = zctl_r[0];
  assign zero_delay_internal   = zctl_r[1];
  assign zero_delay_external   = zctl_r[2];
  assign zero_delay_fb_div     = div_r;

endmodule

`default_nettype wire

// ===== tb/phzds_top_chk.sv
// checker: port-level assertions for the holdover/zero-delay bank
`timescale 1ns/1ns
`default_nettype none
module phzds_top_chk (
  input wire logic       clk,
  input wire logic       resetn,
  input wire logic [9:0] reg_addr,
  input wire logic       reg_wr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic       reg_rvalid,
  input wire logic       lock_detect_pin,
  input wire logic       holdover_enable,
  input wire logic       internal_holdover_en,
  input wire logic       external_holdover_sel,
  input wire logic       holdover_lock_detect,
  input wire logic       zero_delay_en,
  input wire logic       zero_delay_internal,
  input wire logic       zero_delay_external,
  input wire logic [1:0] zero_delay_fb_div
);
  // ****************************************************************
  // assertions
  // ****************************************************************
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  logic wz, wh, um;
  assign wz = reg_wr && reg_addr == phzds_pkg::ADDR_ZERO_DELAY;
  assign wh = reg_wr && reg_addr == phzds_pkg::ADDR_HOLDOVER_CTRL;
  assign um = reg_addr > phzds_pkg::ADDR_STATUS ||
              reg_addr < phzds_pkg::ADDR_HOLDOVER_CTRL;
  a_read_answer: assert property (reg_rd |=> reg_rvalid)
    else $error("read not answered next cycle");
  a_rvalid_pulse: assert property (!reg_rd |=> !reg_rvalid)
    else $error("rvalid without read");
  a_rdata_hold: assert property (!reg_rd |=> $stable(reg_rdata))
    else $error("read data moved without read");
  a_unmapped_zero: assert property (reg_rd && um |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  a_status_top_zero: assert property (reg_rd && reg_addr ==
    phzds_pkg::ADDR_STATUS |=> !reg_rdata[7])
    else $error("status bit 7 set");
  a_zd_write_effect: assert property (wz ##1 !wz |=>
    zero_delay_en == $past(reg_wdata[1], 2) &&
    zero_delay_external == $past(reg_wdata[1] & reg_wdata[2], 2) &&
    zero_delay_fb_div == $past(reg_wdata[4:3], 2))
    else $error("zero-delay controls wrong after write");
  a_zd_modes: assert property (zero_delay_en == (zero_delay_internal ||
    zero_delay_external) && !(zero_delay_internal && zero_delay_external))
    else $error("zero-delay mode outputs inconsistent");
  a_hold_write_effect: assert property (wh ##1 !wh |=>
    holdover_enable == $past(reg_wdata[0], 2) &&
    external_holdover_sel == $past(reg_wdata[1], 2))
    else $error("holdover controls wrong after write");
  a_internal_hold: assert property (internal_holdover_en ==
    (holdover_enable && !external_holdover_sel))
    else $error("internal holdover enable wrong");
  a_lock_pin_low: assert property (!holdover_lock_detect |->
    !$past(lock_detect_pin))
    else $error("lock detect low without pin low");
  c_zd_write: cover property (wz ##1 !wz);
  c_status_read: cover property (reg_rd && reg_addr == phzds_pkg::ADDR_STATUS);
  c_lock_low: cover property (!holdover_lock_detect);
endmodule
bind phzds_top phzds_top_chk i_chk (.clk, .resetn, .reg_addr, .reg_wr,
  .reg_wdata, .reg_rd, .reg_rdata, .reg_rvalid, .lock_detect_pin,
  .holdover_enable, .internal_holdover_en, .external_holdover_sel,
  .holdover_lock_detect, .zero_delay_en, .zero_delay_internal,
  .zero_delay_external, .zero_delay_fb_div);
`default_nettype wire

// ===== tb/phzds_top_tb.sv
// testbench: register accesses and control/status checks for the bank
`timescale 1ns/1ns
`default_nettype none
module phzds_top_tb;
  logic       clk, resetn, reg_wr, reg_rd, pin, reg_rvalid;
  logic       hen, ihen, xsel, hld, zen, zint, zext;
  logic [9:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, v;
  logic [1:0] zdiv;
  logic [6:0] src;
  int         miscompares, checks, i;
  initial
  begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  phzds_top i_dut (.clk(clk), .resetn(resetn), .reg_addr(reg_addr),
    .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
    .vco_cal_done(src[6]), .holdover_active(src[5]),
    .second_reference_selected(src[4]), .vco_freq_above(src[3]),
    .second_reference_input_freq_above(src[2]),
    .first_reference_input_freq_above(src[1]), .digital_lock(src[0]),
    .lock_detect_pin(pin), .holdover_enable(hen),
    .internal_holdover_en(ihen), .external_holdover_sel(xsel),
    .holdover_lock_detect(hld), .zero_delay_en(zen),
    .zero_delay_internal(zint), .zero_delay_external(zext),
    .zero_delay_fb_div(zdiv));
  // ****************************************************************
  // access tasks
  // ****************************************************************
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    checks++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // returns once the decoded controls have settled, two edges after take
  task automatic wr(input logic [9:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
  endtask
  task automatic rd(input logic [9:0] a, input logic [7:0] exp);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    check({7'h0, reg_rvalid}, 8'h01);
    check(reg_rdata, exp);
  endtask
  task automatic settle();
    repeat (2) @(posedge clk);
    #1;
  endtask
  task automatic stop_test();
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  // ****************************************************************
  // test sequence
  // ****************************************************************
  initial
  begin
    {resetn, reg_wr, reg_rd, pin} = 4'h0;
    reg_addr = 10'h000;
    reg_wdata = 8'h00;
    src = 7'h00;
    miscompares = 0;
    checks = 0;
    repeat (8) @(posedge clk);
    resetn <= 1'b1;
    #1;
    check({1'b0, hen, ihen, xsel, hld, zen, zint, zext}, 8'h08);
    rd(phzds_pkg::ADDR_HOLDOVER_CTRL, 8'h00);
    rd(phzds_pkg::ADDR_ZERO_DELAY, 8'h00);
    $display("test reset done");
    // unused bits are written as ones to show they never stick
    for (i = 0; i < 16; i++)
    begin
      v = {3'h7, i[3:0], 1'b1};
      wr(phzds_pkg::ADDR_ZERO_DELAY, v);
      check({6'h0, zdiv}, {6'h0, v[4:3]});
      check({5'h0, zen, zint, zext}, {5'h0, v[1], v[1] & ~v[2], v[1] & v[2]});
      rd(phzds_pkg::ADDR_ZERO_DELAY, v & 8'h1e);
    end
    $display("test zero delay done");
    for (i = 0; i < 16; i++)
    begin
      v = {3'h7, i[3:2], 1'b1, i[1:0]};
      wr(phzds_pkg::ADDR_HOLDOVER_CTRL, v);
      check({5'h0, hen, xsel, ihen}, {5'h0, v[0], v[1], v[0] & ~v[1]});
      rd(phzds_pkg::ADDR_HOLDOVER_CTRL, v & 8'h1b);
    end
    $display("test holdover done");
    wr(phzds_pkg::ADDR_HOLDOVER_CTRL, 8'h00);
    settle();
    check({7'h0, hld}, 8'h01);
    wr(phzds_pkg::ADDR_HOLDOVER_CTRL, 8'h08);
    check({7'h0, hld}, 8'h00);
    @(posedge clk);
    pin <= 1'b1;
    settle();
    check({7'h0, hld}, 8'h01);
    $display("test lock pin done");
    wr(phzds_pkg::ADDR_HOLDOVER_CTRL, 8'h00);
    for (i = 0; i < 7; i++)
    begin
      @(posedge clk);
      src <= 7'h01 << i;
      rd(phzds_pkg::ADDR_STATUS, {1'b0, 7'h01 << i});
    end
    @(posedge clk);
    src <= 7'h55;
    wr(phzds_pkg::ADDR_HOLDOVER_CTRL, 8'h10);
    @(posedge clk);
    src <= 7'h2a;
    wr(phzds_pkg::ADDR_STATUS, 8'hff);
    rd(phzds_pkg::ADDR_STATUS, 8'h55);
    wr(phzds_pkg::ADDR_HOLDOVER_CTRL, 8'h00);
    rd(phzds_pkg::ADDR_STATUS, 8'h2a);
    $display("test status done");
    wr(10'h020, 8'hff);
    rd(10'h000, 8'h00);
    rd(10'h3ff, 8'h00);
    rd(phzds_pkg::ADDR_ZERO_DELAY, 8'h1e);
    @(posedge clk);
    resetn <= 1'b0;
    repeat (2) @(posedge clk);
    resetn <= 1'b1;
    rd(phzds_pkg::ADDR_ZERO_DELAY, 8'h00);
    $display("test unmapped and reset done");
    stop_test();
  end
endmodule
`default_nettype wire
